// ===== core/xcvr_ctrl.v
// Control and status register bank of an optical transceiver, written over a three-wire serial link.
// Assumes the link pins, detector inputs and the disable pin are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "xcvr_ctrl_defs.vh"

module xcvr_ctrl #(
  parameter DAC_WIDTH = 9,
  parameter SWITCH_CYCLES = (`MODE_SWITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter RAMP_CYCLES = (`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Three-wire serial link
  input wire link_clk,
  input wire link_select,
  input wire link_data_in,
  output wire link_data_out,
  output wire link_data_oe,
  // Pins and detectors
  input wire mode_select_pin,
  input wire tx_disable,
  input wire hard_fault_detect,
  input wire loss_detect,
  input wire tx_activity_detect,
  output wire fault_out,
  output wire fault_oe,
  output wire signal_loss,
  // Receive path controls
  output wire high_bandwidth_mode,
  output wire receive_polarity_bit,
  output wire offset_loop_enable,
  output wire receive_deemphasis_enable,
  output wire rx_output_enable,
  output wire reduced_slew,
  output wire fast_switch_active,
  output wire cap_switch_active,
  output wire [7:0] rx_output_amplitude,
  output wire [5:0] signal_loss_threshold,
  // Transmit path controls
  output wire transmit_polarity_bit,
  output wire [7:0] pulse_width_control,
  output wire transmit_deemphasis_enable,
  output wire [7:0] transmit_deemphasis_setting,
  output wire [DAC_WIDTH-1:0] bias_dac,
  output wire [DAC_WIDTH-1:0] mod_dac
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_WRITE = 2'h2;
  localparam ST_READ = 2'h3;

  // Two-stage synchronisers; the third stage only serves edge detection.
  reg scl_s1_ff, scl_s2_ff, scl_s3_ff;
  reg cs_s1_ff, cs_s2_ff;
  reg sda_s1_ff, sda_s2_ff;
  reg pin_s1_ff, pin_s2_ff;
  reg dis_s1_ff, dis_s2_ff, dis_s3_ff;
  reg hf_s1_ff, hf_s2_ff;
  reg los_s1_ff, los_s2_ff;
  reg act_s1_ff, act_s2_ff;

  always @(posedge clk) begin
    if (!resetn) begin
      scl_s1_ff <= 1'b0;
      scl_s2_ff <= 1'b0;
      scl_s3_ff <= 1'b0;
      cs_s1_ff <= 1'b0;
      cs_s2_ff <= 1'b0;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      dis_s1_ff <= 1'b1;
      dis_s2_ff <= 1'b1;
      dis_s3_ff <= 1'b1;
      hf_s1_ff <= 1'b0;
      hf_s2_ff <= 1'b0;
      los_s1_ff <= 1'b0;
      los_s2_ff <= 1'b0;
      act_s1_ff <= 1'b0;
      act_s2_ff <= 1'b0;
    end else begin
      scl_s1_ff <= link_clk;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      cs_s1_ff <= link_select;
      cs_s2_ff <= cs_s1_ff;
      sda_s1_ff <= link_data_in;
      sda_s2_ff <= sda_s1_ff;
      pin_s1_ff <= mode_select_pin;
      pin_s2_ff <= pin_s1_ff;
      dis_s1_ff <= tx_disable;
      dis_s2_ff <= dis_s1_ff;
      dis_s3_ff <= dis_s2_ff;
      hf_s1_ff <= hard_fault_detect;
      hf_s2_ff <= hf_s1_ff;
      los_s1_ff <= loss_detect;
      los_s2_ff <= los_s1_ff;
      act_s1_ff <= tx_activity_detect;
      act_s2_ff <= act_s1_ff;
    end
  end

  wire scl_rise = scl_s2_ff & ~scl_s3_ff;
  wire scl_fall = ~scl_s2_ff & scl_s3_ff;
  wire dis_rise = dis_s2_ff & ~dis_s3_ff;

  // Serial frame engine.
  reg [1:0] state_ff;
  reg [3:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg [6:0] addr_ff;
  reg [7:0] rd_shift_ff;
  reg sda_drive_ff;
  reg wr_strobe_ff;
  reg [7:0] wr_data_ff;

  // Control registers.
  reg [7:0] rx_ctrl_ff;
  reg [7:0] mode_ctrl_ff;
  reg [7:0] amp_ff;
  reg [5:0] los_thr_ff;
  reg [7:0] tx_ctrl_ff;
  reg [7:0] pw_ff;
  reg [7:0] txde_ff;
  reg [8:0] bias_set_ff;
  reg [7:0] bias_max_ff;
  reg [7:0] bias_inc_ff;
  reg [8:0] mod_set_ff;
  reg [7:0] mod_max_ff;
  reg [7:0] mod_inc_ff;
  reg bias_err_ff;
  reg mod_err_ff;
  reg fault_ff;

  wire [7:0] rx_status = {7'h00, los_s2_ff};
  wire [7:0] tx_status = {4'h0, fault_ff, mod_err_ff, bias_err_ff, act_s2_ff};

  reg [7:0] rd_data;
  always @* begin
    case (addr_ff)
      `OFF_RX_CTRL: rd_data = rx_ctrl_ff;
      `OFF_MODE_CTRL: rd_data = mode_ctrl_ff;
      `OFF_RX_STATUS: rd_data = rx_status;
      `OFF_RX_AMPLITUDE: rd_data = amp_ff;
      `OFF_LOSS_THRESHOLD: rd_data = {2'h0, los_thr_ff};
      `OFF_TX_CTRL: rd_data = tx_ctrl_ff;
      `OFF_TX_STATUS: rd_data = tx_status;
      `OFF_BIAS_SETTING: rd_data = bias_set_ff[8:1];
      `OFF_BIAS_MAXIMUM: rd_data = bias_max_ff;
      `OFF_BIAS_INCREMENT: rd_data = bias_inc_ff;
      `OFF_MOD_SETTING: rd_data = mod_set_ff[8:1];
      `OFF_MOD_MAXIMUM: rd_data = mod_max_ff;
      `OFF_MOD_INCREMENT: rd_data = mod_inc_ff;
      `OFF_PULSE_WIDTH: rd_data = pw_ff;
      `OFF_TX_DEEMPHASIS: rd_data = txde_ff;
      default: rd_data = 8'h00;
    endcase
  end

  // Deselecting ends the frame and returns the engine to idle at once.
  always @(posedge clk) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      addr_ff <= 7'h00;
      rd_shift_ff <= 8'h00;
      sda_drive_ff <= 1'b0;
      wr_strobe_ff <= 1'b0;
      wr_data_ff <= 8'h00;
    end else begin
      wr_strobe_ff <= 1'b0;
      if (!cs_s2_ff) begin
        state_ff <= ST_IDLE;
        bit_cnt_ff <= 4'h0;
        sda_drive_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            state_ff <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_s2_ff};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'h7) begin
                addr_ff <= shift_ff[6:0];
                state_ff <= sda_s2_ff ? ST_READ : ST_WRITE;
              end
            end
          end
          ST_WRITE: begin
            if (scl_rise && bit_cnt_ff != 4'h0) begin
              shift_ff <= {shift_ff[6:0], sda_s2_ff};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'hF) begin
                wr_data_ff <= {shift_ff[6:0], sda_s2_ff};
                wr_strobe_ff <= 1'b1;
                bit_cnt_ff <= 4'h0;
              end
            end
          end
          ST_READ: begin
            if (scl_fall && bit_cnt_ff == 4'h8) begin
              rd_shift_ff <= {rd_data[6:0], 1'b0};
              sda_drive_ff <= ~rd_data[7];
              bit_cnt_ff <= 4'h9;
            end else if (scl_fall && bit_cnt_ff > 4'h8) begin
              rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
              sda_drive_ff <= ~rd_shift_ff[7];
              bit_cnt_ff <= (bit_cnt_ff == 4'hF) ? 4'h0 : bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == 4'h0) begin
              sda_drive_ff <= 1'b0;
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // The data line is open drain: only a zero is driven.
  assign link_data_out = 1'b0;
  assign link_data_oe = sda_drive_ff;

  // Increment arithmetic on the full nine bits.
  function [9:0] step_sum;
    input [8:0] cur;
    input [4:0] raw;
    reg [4:0] lim;
    begin
      lim = raw;
      if (raw[4] && raw < 5'h18)
        lim = 5'h18;
      else if (!raw[4] && raw > 5'h07)
        lim = 5'h07;
      step_sum = {1'b0, cur} + {{5{lim[4]}}, lim};
    end
  endfunction

  wire wr_bias_inc = wr_strobe_ff && addr_ff == `OFF_BIAS_INCREMENT;
  wire wr_mod_inc = wr_strobe_ff && addr_ff == `OFF_MOD_INCREMENT;
  wire [9:0] bias_sum = step_sum(bias_set_ff, wr_data_ff[4:0]);
  wire [9:0] mod_sum = step_sum(mod_set_ff, wr_data_ff[4:0]);
  // A result below zero wraps into bit 9 and is refused like an overflow.
  wire bias_over = bias_sum[9] || bias_sum[8:1] > bias_max_ff;
  wire mod_over = mod_sum[9] || mod_sum[8:1] > mod_max_ff;
  // Ten bits hold the deemphasis sum with the step's sign, so both end stops are seen.
  wire [9:0] de_sum = {2'b00, txde_ff} + mod_sum - {1'b0, mod_set_ff};

  always @(posedge clk) begin
    if (!resetn) begin
      rx_ctrl_ff <= `RST_RX_CTRL;
      mode_ctrl_ff <= `RST_MODE_CTRL;
      amp_ff <= `RST_RX_AMPLITUDE;
      los_thr_ff <= `RST_LOSS_THRESHOLD;
      tx_ctrl_ff <= `RST_TX_CTRL;
      pw_ff <= `RST_PULSE_WIDTH;
      txde_ff <= `RST_TX_DEEMPHASIS;
      bias_set_ff <= 9'h000;
      bias_max_ff <= 8'h00;
      bias_inc_ff <= 8'h00;
      mod_set_ff <= 9'h000;
      mod_max_ff <= 8'h00;
      mod_inc_ff <= 8'h00;
    end else if (wr_strobe_ff) begin
      case (addr_ff)
        `OFF_RX_CTRL: rx_ctrl_ff <= wr_data_ff;
        `OFF_MODE_CTRL: mode_ctrl_ff <= wr_data_ff;
        `OFF_RX_AMPLITUDE: amp_ff <= wr_data_ff;
        `OFF_LOSS_THRESHOLD: los_thr_ff <= wr_data_ff[5:0];
        `OFF_TX_CTRL: tx_ctrl_ff <= wr_data_ff;
        `OFF_PULSE_WIDTH: pw_ff <= wr_data_ff;
        `OFF_TX_DEEMPHASIS: txde_ff <= wr_data_ff;
        `OFF_BIAS_SETTING: bias_set_ff[8:1] <= wr_data_ff;
        `OFF_BIAS_MAXIMUM: bias_max_ff <= wr_data_ff;
        `OFF_BIAS_INCREMENT: begin
          bias_inc_ff <= wr_data_ff;
          if (!bias_over)
            bias_set_ff <= bias_sum[8:0];
        end
        `OFF_MOD_SETTING: mod_set_ff[8:1] <= wr_data_ff;
        `OFF_MOD_MAXIMUM: mod_max_ff <= wr_data_ff;
        `OFF_MOD_INCREMENT: begin
          mod_inc_ff <= wr_data_ff;
          if (!mod_over) begin
            mod_set_ff <= mod_sum[8:0];
            // Deemphasis tracks the modulation step, held at its end stops.
            if (de_sum[9] || de_sum[8])
              txde_ff <= wr_data_ff[4] ? 8'h00 : 8'hFF;
            else
              txde_ff <= de_sum[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Warning flags and fault latch; a set in the clearing cycle wins.
  always @(posedge clk) begin
    if (!resetn) begin
      bias_err_ff <= 1'b0;
      mod_err_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      bias_err_ff <= (wr_bias_inc & bias_over) | (bias_err_ff & ~dis_rise);
      mod_err_ff <= (wr_mod_inc & mod_over) | (mod_err_ff & ~dis_rise);
      fault_ff <= hf_s2_ff | (fault_ff & ~dis_s2_ff);
    end
  end

  assign fault_out = 1'b0;
  assign fault_oe = ~fault_ff;

  // Receive path.
  wire los_active = rx_ctrl_ff[`RXC_LOSS_ENABLE] & los_s2_ff;
  assign signal_loss = los_active ^ rx_ctrl_ff[`RXC_LOSS_POLARITY];
  assign high_bandwidth_mode = mode_ctrl_ff[`MDC_FROM_PIN] ? pin_s2_ff : mode_ctrl_ff[`MDC_HIGH_BANDWIDTH];
  assign reduced_slew = ~high_bandwidth_mode & ~mode_ctrl_ff[`MDC_SLEW_RATE];
  assign receive_polarity_bit = rx_ctrl_ff[`RXC_POLARITY];
  assign offset_loop_enable = rx_ctrl_ff[`RXC_OFFSET_LOOP];
  assign receive_deemphasis_enable = rx_ctrl_ff[`RXC_DEEMPHASIS];
  assign rx_output_enable = rx_ctrl_ff[`RXC_ENABLE] & ~(rx_ctrl_ff[`RXC_SQUELCH] & los_active);
  assign rx_output_amplitude = amp_ff;
  assign signal_loss_threshold = los_thr_ff;

  // Mode change window; the speedup and capacitor bits pick which assists run.
  reg mode_prev_ff;
  reg [15:0] switch_cnt_ff;
  always @(posedge clk) begin
    if (!resetn) begin
      mode_prev_ff <= 1'b0;
      switch_cnt_ff <= 16'h0000;
    end else begin
      mode_prev_ff <= high_bandwidth_mode;
      if (mode_prev_ff != high_bandwidth_mode)
        switch_cnt_ff <= SWITCH_CYCLES[15:0];
      else if (switch_cnt_ff != 16'h0000)
        switch_cnt_ff <= switch_cnt_ff - 16'h0001;
    end
  end
  assign fast_switch_active = (switch_cnt_ff != 16'h0000) & mode_ctrl_ff[`MDC_SPEEDUP];
  assign cap_switch_active = (switch_cnt_ff != 16'h0000) & mode_ctrl_ff[`MDC_CAP_SWITCH];

  // Transmit path.
  assign transmit_polarity_bit = tx_ctrl_ff[`TXC_POLARITY];
  assign pulse_width_control = pw_ff;
  assign transmit_deemphasis_enable = tx_ctrl_ff[`TXC_DEEMPHASIS];
  assign transmit_deemphasis_setting = tx_ctrl_ff[`TXC_DEEMPHASIS] ? txde_ff : 8'h00;

  // Laser currents step up toward their settings to avoid overshoot; a lower setting is taken whole at the next ramp tick.
  wire laser_on = ~dis_s2_ff & ~fault_ff & tx_ctrl_ff[`TXC_ENABLE];
  reg [15:0] ramp_cnt_ff;
  reg [DAC_WIDTH-1:0] bias_dac_ff;
  reg [DAC_WIDTH-1:0] mod_dac_ff;
  wire ramp_tick = (ramp_cnt_ff == 16'h0000);
  always @(posedge clk) begin
    if (!resetn) begin
      ramp_cnt_ff <= 16'h0000;
      bias_dac_ff <= {DAC_WIDTH{1'b0}};
      mod_dac_ff <= {DAC_WIDTH{1'b0}};
    end else begin
      ramp_cnt_ff <= ramp_tick ? (RAMP_CYCLES[15:0] - 16'h0001) : ramp_cnt_ff - 16'h0001;
      if (!laser_on) begin
        bias_dac_ff <= {DAC_WIDTH{1'b0}};
        mod_dac_ff <= {DAC_WIDTH{1'b0}};
      end else if (ramp_tick) begin
        if (bias_dac_ff < bias_set_ff)
          bias_dac_ff <= bias_dac_ff + 1'b1;
        else
          bias_dac_ff <= bias_set_ff;
        if (mod_dac_ff < mod_set_ff)
          mod_dac_ff <= mod_dac_ff + 1'b1;
        else
          mod_dac_ff <= mod_set_ff;
      end
    end
  end
  assign bias_dac = bias_dac_ff;
  assign mod_dac = mod_dac_ff;

endmodule
`default_nettype wire

// ===== inc/xcvr_ctrl_defs.vh
// Register offsets, field positions, reset values and timing figures of the transceiver control logic.
// Included by the control module; holds definitions only.
`ifndef XCVR_CTRL_DEFS_VH
`define XCVR_CTRL_DEFS_VH

// Three-wire frame: seven address bits, one direction bit, eight data bits.
`define ADDR_BITS 7
`define FRAME_BITS 16

// Register offsets (seven-bit addresses).
`define OFF_RX_CTRL 7'h00
`define OFF_MODE_CTRL 7'h01
`define OFF_RX_STATUS 7'h02
`define OFF_RX_AMPLITUDE 7'h03
`define OFF_LOSS_THRESHOLD 7'h04
`define OFF_TX_CTRL 7'h05
`define OFF_TX_STATUS 7'h06
`define OFF_BIAS_SETTING 7'h07
`define OFF_BIAS_MAXIMUM 7'h08
`define OFF_BIAS_INCREMENT 7'h09
`define OFF_MOD_SETTING 7'h0A
`define OFF_MOD_MAXIMUM 7'h0B
`define OFF_MOD_INCREMENT 7'h0C
`define OFF_PULSE_WIDTH 7'h0D
`define OFF_TX_DEEMPHASIS 7'h0E

// Receive control fields.
`define RXC_POLARITY 0
`define RXC_OFFSET_LOOP 1
`define RXC_DEEMPHASIS 2
`define RXC_SQUELCH 3
`define RXC_ENABLE 4
`define RXC_LOSS_POLARITY 5
`define RXC_LOSS_ENABLE 6

// Mode control fields.
`define MDC_HIGH_BANDWIDTH 0
`define MDC_SLEW_RATE 1
`define MDC_SPEEDUP 2
`define MDC_CAP_SWITCH 3
`define MDC_FROM_PIN 4

// Transmit control fields.
`define TXC_POLARITY 0
`define TXC_ENABLE 1
`define TXC_DEEMPHASIS 2

// Transmit status fields.
`define TXS_INPUT_PRESENT 0
`define TXS_BIAS_ERROR 1
`define TXS_MOD_ERROR 2
`define TXS_FAULT 3

// Reset values.
`define RST_RX_CTRL 8'h52
`define RST_MODE_CTRL 8'h00
`define RST_RX_AMPLITUDE 8'h80
`define RST_LOSS_THRESHOLD 6'h10
`define RST_TX_CTRL 8'h02
`define RST_PULSE_WIDTH 8'h80
`define RST_TX_DEEMPHASIS 8'h00

// Timing figures.
`define CLK_PERIOD_NS 20
`define MODE_SWITCH_NS 10000
`define RAMP_STEP_NS 1000

`endif

// ===== testbench/link_master.sv
// Controller model on the three-wire link: 16-bit frames, MSB first, open-drain data line.
// Assumes frames are started on a clk falling edge; the link clock stands low outside frames.
`timescale 1ns/1ns
`default_nettype none
module link_master #(
  parameter HALF_NS = 80
) (
  // Three-wire link
  output logic link_clk,
  output logic link_select,
  output wire logic link_data_in,
  input wire logic link_data_oe
);
  logic drv_en = 1'h0;
  logic drv_bit = 1'h0;
  initial link_clk = 1'h0;
  initial link_select = 1'h0;
  // The pull-up returns a released line high, so a stale bit is never read back.
  assign link_data_in = (drv_en ? drv_bit : 1'h1) & ~link_data_oe;
  task automatic frame(input logic [6:0] a, input logic rd, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] word;
    word = {a, rd, d};
    q = 8'h00;
    link_select = 1'h1;
    drv_en = 1'h1;
    #(2 * HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      if (i < 8 && rd) drv_en = 1'h0;
      drv_bit = word[i];
      #HALF_NS link_clk = 1'h1;
      if (i < 8) q[i] = link_data_in;
      #HALF_NS link_clk = 1'h0;
    end
    #(2 * HALF_NS);
    drv_en = 1'h0;
    link_select = 1'h0;
    #(2 * HALF_NS);
  endtask
endmodule
`default_nettype wire

// ===== testbench/xcvr_ctrl_bench.sv
// Self-checking bench of the transceiver control logic.
// Assumes link_master as the controller; short switch and ramp counts keep the run brief.
`timescale 1ns/1ns
`default_nettype none
module xcvr_ctrl_bench;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic mode_select_pin = 1'h0;
  logic tx_disable = 1'h1;
  logic hard_fault_detect = 1'h0;
  logic loss_detect = 1'h0;
  logic tx_activity_detect = 1'h0;
  int error_cnt = 0;
  int cmp_count = 0;
  wire link_clk, link_select, link_data_in, link_data_oe, fault_oe, signal_loss;
  wire high_bandwidth_mode, offset_loop_enable, rx_output_enable, reduced_slew;
  wire [8:0] bias_dac, mod_dac;
  wire receive_polarity_bit, receive_deemphasis_enable, transmit_polarity_bit, transmit_deemphasis_enable;
  wire [7:0] rx_output_amplitude, pulse_width_control, transmit_deemphasis_setting;
  wire [5:0] signal_loss_threshold;
  // Row: write flag and address, write data, expected read-back.
  logic [23:0] rows [16] = '{24'h000052, 24'h010000, 24'h030080, 24'h040010, 24'h050002, 24'h0D0080,
    24'h83A5A5, 24'h84FF3F, 24'h8D3C3C, 24'h8E5A5A, 24'hFF1200, 24'h882020, 24'h8B1111,
    24'h870C0C, 24'h8A1010, 24'h86FF00};
  // Row: receive enable, squelch, loss input, expected output enable.
  logic [3:0] gate_rows [4] = '{4'h6, 4'hB, 4'hD, 4'hE};
  // Row: mode byte, then pin, high bandwidth, reduced slew.
  logic [11:0] mode_rows [5] = '{12'h001, 12'h020, 12'h052, 12'h106, 12'h101};
  always #10 clk = ~clk;
  link_master u_link_master (.link_clk(link_clk), .link_select(link_select), .link_data_in(link_data_in),
    .link_data_oe(link_data_oe));
  xcvr_ctrl #(.SWITCH_CYCLES(10), .RAMP_CYCLES(2)) u_xcvr_ctrl (.clk(clk), .resetn(resetn),
    .link_clk(link_clk), .link_select(link_select), .link_data_in(link_data_in), .link_data_out(),
    .link_data_oe(link_data_oe), .mode_select_pin(mode_select_pin), .tx_disable(tx_disable),
    .hard_fault_detect(hard_fault_detect), .loss_detect(loss_detect), .tx_activity_detect(tx_activity_detect),
    .fault_out(), .fault_oe(fault_oe), .signal_loss(signal_loss), .high_bandwidth_mode(high_bandwidth_mode),
    .receive_polarity_bit(receive_polarity_bit), .offset_loop_enable(offset_loop_enable),
    .receive_deemphasis_enable(receive_deemphasis_enable),
    .rx_output_enable(rx_output_enable), .reduced_slew(reduced_slew), .fast_switch_active(),
    .cap_switch_active(), .rx_output_amplitude(rx_output_amplitude),
    .signal_loss_threshold(signal_loss_threshold), .transmit_polarity_bit(transmit_polarity_bit),
    .pulse_width_control(pulse_width_control), .transmit_deemphasis_enable(transmit_deemphasis_enable),
    .transmit_deemphasis_setting(transmit_deemphasis_setting),
    .bias_dac(bias_dac), .mod_dac(mod_dac));
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_link_master.frame(a, 1'h0, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    u_link_master.frame(a, 1'h1, 8'h00, q);
    compare({8'h00, q & m}, {8'h00, e});
  endtask
  // An increment is judged by reading the setting two addresses below it.
  task automatic step(input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
    wr(a, d);
    rd(a - 7'h02, 8'hFF, e);
  endtask
  task automatic do_reset();
    @(negedge clk) resetn = 1'h0;
    repeat (10) @(negedge clk);
    resetn = 1'h1;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    #1000000;
    error_cnt++;
    test_done();
  end
  initial begin
    int k;
    do_reset();
    foreach (rows[i]) begin
      if (rows[i][23]) wr(rows[i][22:16], rows[i][15:8]);
      rd(rows[i][22:16], 8'hFF, rows[i][7:0]);
    end
    compare({rx_output_amplitude, pulse_width_control}, 16'hA53C);
    compare({10'h000, signal_loss_threshold}, 16'h003F);
    foreach (mode_rows[i]) begin
      @(negedge clk) mode_select_pin = mode_rows[i][2];
      wr(7'h01, mode_rows[i][11:4]);
      compare({14'h0, high_bandwidth_mode, reduced_slew}, {14'h0, mode_rows[i][1:0]});
    end
    foreach (gate_rows[i]) begin
      @(negedge clk) loss_detect = gate_rows[i][1];
      wr(7'h00, {2'h1, 1'h0, gate_rows[i][3:2], 3'h0});
      compare({15'h0, rx_output_enable}, {15'h0, gate_rows[i][0]});
      compare({15'h0, signal_loss}, {15'h0, gate_rows[i][1]});
    end
    wr(7'h00, 8'h05);
    compare({14'h0, receive_polarity_bit, receive_deemphasis_enable}, 16'h0003);
    wr(7'h00, 8'h60);
    compare({14'h0, signal_loss, offset_loop_enable}, 16'h0000);
    wr(7'h00, 8'h20);
    compare({15'h0, signal_loss}, 16'h0001);
    step(7'h09, 8'h07, 8'h0F);
    step(7'h09, 8'hF9, 8'h0C);
    step(7'h09, 8'h10, 8'h08);
    wr(7'h08, 8'h08);
    step(7'h09, 8'h01, 8'h08);
    step(7'h09, 8'h01, 8'h08);
    rd(7'h06, 8'h02, 8'h02);
    step(7'h09, 8'h1F, 8'h08);
    step(7'h0C, 8'h03, 8'h11);
    rd(7'h0E, 8'hFF, 8'h5D);
    step(7'h0C, 8'h07, 8'h11);
    rd(7'h06, 8'h04, 8'h04);
    wr(7'h05, 8'h07);
    compare({6'h00, transmit_polarity_bit, transmit_deemphasis_enable, transmit_deemphasis_setting}, 16'h035D);
    @(negedge clk) tx_disable = 1'h0;
    repeat (5) @(negedge clk);
    tx_disable = 1'h1;
    repeat (5) @(negedge clk);
    rd(7'h06, 8'h06, 8'h00);
    @(negedge clk) tx_disable = 1'h0;
    for (k = 0; k < 500 && (bias_dac !== 9'h010 || mod_dac !== 9'h023); k++) @(negedge clk);
    compare({7'h00, bias_dac}, 16'h0010);
    compare({7'h00, mod_dac}, 16'h0023);
    @(negedge clk) hard_fault_detect = 1'h1;
    tx_activity_detect = 1'h1;
    repeat (10) @(negedge clk);
    hard_fault_detect = 1'h0;
    repeat (10) @(negedge clk);
    compare({15'h0, fault_oe}, 16'h0000);
    rd(7'h06, 8'h09, 8'h09);
    @(negedge clk) tx_disable = 1'h1;
    repeat (10) @(negedge clk);
    compare({7'h00, bias_dac | mod_dac}, 16'h0000);
    tx_disable = 1'h0;
    repeat (10) @(negedge clk);
    compare({15'h0, fault_oe}, 16'h0001);
    do_reset();
    rd(7'h03, 8'hFF, 8'h80);
    test_done();
  end
endmodule
`default_nettype wire

// ===== testbench/xcvr_ctrl_sva.sv
// Concurrent checks on the ports of the transceiver control block.
// Assumes one clk domain with synchronous active-low resetn; bound to every xcvr_ctrl.
`timescale 1ns/1ns
`default_nettype none
`include "xcvr_ctrl_defs.vh"
module xcvr_ctrl_sva #(
  parameter DAC_WIDTH = 9,
  parameter SWITCH_CYCLES = 500
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins and controls
  input wire logic tx_disable,
  input wire logic hard_fault_detect,
  input wire logic fault_oe,
  input wire logic high_bandwidth_mode,
  input wire logic reduced_slew,
  input wire logic fast_switch_active,
  input wire logic [7:0] rx_output_amplitude,
  input wire logic [7:0] pulse_width_control,
  input wire logic transmit_deemphasis_enable,
  input wire logic [7:0] transmit_deemphasis_setting,
  input wire logic [DAC_WIDTH-1:0] bias_dac,
  input wire logic [DAC_WIDTH-1:0] mod_dac
);
  logic [15:0] sw_cnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Length of the open speedup window, read when the window closes.
  always @(posedge clk) begin
    if (!resetn || !fast_switch_active) begin
      sw_cnt_ff <= 16'h0000;
    end else begin
      sw_cnt_ff <= sw_cnt_ff + 16'h0001;
    end
  end
  chk_slew_ignored: assert property (high_bandwidth_mode |-> !reduced_slew)
    else $error("reduced slew while in high bandwidth mode");
  chk_laser_off: assert property (tx_disable [*6] |-> bias_dac == 0 && mod_dac == 0)
    else $error("laser currents on while disabled");
  chk_bias_ramp: assert property (bias_dac > $past(bias_dac) |-> bias_dac == $past(bias_dac) + 1'b1)
    else $error("bias current rose by more than one step");
  chk_mod_ramp: assert property (mod_dac > $past(mod_dac) |-> mod_dac == $past(mod_dac) + 1'b1)
    else $error("modulation current rose by more than one step");
  chk_fault_set: assert property (hard_fault_detect [*5] |-> !fault_oe)
    else $error("fault output not raised by hard fault");
  chk_fault_hold: assert property (!tx_disable [*4] ##0 !fault_oe |=> !fault_oe)
    else $error("fault output dropped without disable");
  chk_switch_len: assert property ($fell(fast_switch_active) |-> sw_cnt_ff >= SWITCH_CYCLES - 1 && sw_cnt_ff <= SWITCH_CYCLES + 1)
    else $error("mode switch window of wrong length");
  chk_reset_values: assert property ($rose(resetn) |-> rx_output_amplitude == `RST_RX_AMPLITUDE && pulse_width_control == `RST_PULSE_WIDTH && bias_dac == 0)
    else $error("outputs not at defaults after reset");
  chk_deemph_gate: assert property (!transmit_deemphasis_enable |-> transmit_deemphasis_setting == 8'h00)
    else $error("transmit deemphasis applied while disabled");
  cover property ($fell(fast_switch_active));
  cover property (!fault_oe);
  cover property (bias_dac > $past(bias_dac));
endmodule
bind xcvr_ctrl xcvr_ctrl_sva #(.DAC_WIDTH(DAC_WIDTH), .SWITCH_CYCLES(SWITCH_CYCLES)) u_xcvr_ctrl_sva (
  .clk(clk), .resetn(resetn), .tx_disable(tx_disable), .hard_fault_detect(hard_fault_detect),
  .fault_oe(fault_oe), .high_bandwidth_mode(high_bandwidth_mode), .reduced_slew(reduced_slew),
  .fast_switch_active(fast_switch_active), .rx_output_amplitude(rx_output_amplitude),
  .pulse_width_control(pulse_width_control), .transmit_deemphasis_enable(transmit_deemphasis_enable),
  .transmit_deemphasis_setting(transmit_deemphasis_setting), .bias_dac(bias_dac), .mod_dac(mod_dac)
);
`default_nettype wire
